// >>> core/icpt_pkg.sv
/*
  shared constants of the input capture timer: register map, field layout,
  reset values, edge and filter clock encodings, bus responses.
  assumes a 32-bit axi4-lite register bus with byte addresses.
*/
`default_nettype none

package icpt_pkg;

  // ==========================================================
  // register map
  localparam int         ADDR_W      = 6;
  localparam logic [5:0] OFF_PER_EN  = 6'h00;
  localparam logic [5:0] OFF_MODE    = 6'h04;
  localparam logic [5:0] OFF_IOCTL   = 6'h08;
  localparam logic [5:0] OFF_IEN     = 6'h0c;
  localparam logic [5:0] OFF_STAT    = 6'h10;
  localparam logic [5:0] OFF_CLR     = 6'h14;
  localparam logic [5:0] OFF_CNT     = 6'h18;
  localparam logic [5:0] OFF_GRA     = 6'h1c;
  localparam logic [5:0] OFF_GRB     = 6'h20;

  // ==========================================================
  // fields
  localparam int         PER_GATE_BIT = 6;
  localparam int         MODE_RUN_BIT = 7;
  localparam int         MODE_FCK_LSB = 4;
  localparam int         MODE_DFB_BIT = 3;
  localparam int         MODE_DFA_BIT = 2;
  localparam logic [7:0] MODE_MASK    = 8'hbc;
  localparam int         IO_A_LSB     = 0;
  localparam int         IO_B_LSB     = 4;
  localparam int         IO_MODE_OFS  = 2;
  localparam logic [7:0] IOCTL_MASK   = 8'h77;
  localparam int         EV_CAPA_BIT  = 0;
  localparam int         EV_CAPB_BIT  = 1;
  localparam int         EV_OVF_BIT   = 3;
  localparam logic [7:0] EV_MASK      = 8'h0b;
  localparam logic [7:0] RST_BYTE     = 8'h00;

  // ==========================================================
  // encodings
  typedef enum logic [1:0] {
    EDGE_RISE = 2'h0,
    EDGE_FALL = 2'h1,
    EDGE_BOTH = 2'h2,
    EDGE_BAD  = 2'h3
  } icpt_edge_t;

  typedef enum logic [1:0] {
    FCK_DIV32 = 2'h0,
    FCK_DIV8  = 2'h1,
    FCK_FULL  = 2'h2,
    FCK_SRC   = 2'h3
  } icpt_fck_t;

  localparam logic [4:0] DIV32_LAST  = 5'h1f;
  localparam logic [2:0] DIV8_LAST   = 3'h7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// >>> core/icpt_chan_if.sv
/*
  link between the timer core and one capture pin conditioner.
  assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface icpt_chan_if;
  logic       filt_tick;
  logic       filt_en;
  logic [1:0] edge_sel;
  logic       edge_evt;

  modport ctl  (output filt_tick, output filt_en, output edge_sel, input edge_evt);
  modport chan (input filt_tick, input filt_en, input edge_sel, output edge_evt);
endinterface

`default_nettype wire

// >>> core/icpt_chan.sv
/*
  one capture pin: two-stage synchroniser, optional sampling filter and
  edge selection, giving a one-cycle capture event.
  assumes the pin is asynchronous to clk and reset is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module icpt_chan #(
  parameter int FILT_AGREE = 3
) (
  // clock and control
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  // pin
  input  wire logic       pin,
  // core side
  icpt_chan_if.chan       ch
);

  if (FILT_AGREE < 2 || FILT_AGREE > 4) begin : g_bad_agree
    $error("filter agreement must be 2 to 4 samples");
  end

  logic [1:0]            sync_reg;
  logic [1:0]            sync_next;
  logic [FILT_AGREE-1:0] samp_reg;
  logic [FILT_AGREE-1:0] samp_next;
  logic                  lvl_reg;
  logic                  lvl_next;
  logic                  evt_reg;
  logic                  evt_next;
  logic                  rise;
  logic                  fall;

  // ==========================================================
  // next state
  always_comb begin
    sync_next = {sync_reg[0], pin};
    samp_next = samp_reg;
    lvl_next  = lvl_reg;
    if (ch.filt_tick) begin
      samp_next = {samp_reg[FILT_AGREE-2:0], sync_reg[1]};
    end
    if (!ch.filt_en) begin
      lvl_next = sync_reg[1];
    end else if (ch.filt_tick && (&samp_next)) begin
      lvl_next = 1'b1;
    end else if (ch.filt_tick && !(|samp_next)) begin
      lvl_next = 1'b0;
    end
    rise = lvl_next & ~lvl_reg;
    fall = ~lvl_next & lvl_reg;
    unique case (ch.edge_sel)
      icpt_pkg::EDGE_RISE: evt_next = rise;
      icpt_pkg::EDGE_FALL: evt_next = fall;
      icpt_pkg::EDGE_BOTH: evt_next = rise | fall;
      default:             evt_next = 1'b0;
    endcase
  end

  // ==========================================================
  // registers; a pin high at reset release shows as one rising edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync_reg <= '0;
      samp_reg <= '0;
      lvl_reg  <= 1'b0;
      evt_reg  <= 1'b0;
    end else if (ce) begin
      sync_reg <= sync_next;
      samp_reg <= samp_next;
      lvl_reg  <= lvl_next;
      evt_reg  <= evt_next;
    end
  end

  assign ch.edge_evt = evt_reg;

  // ==========================================================
  // checks
  chk_both_edges:
    assert property (@(posedge clk) disable iff (!resetn)
      (ce && ch.edge_sel == icpt_pkg::EDGE_BOTH && lvl_next != lvl_reg) |=> evt_reg)
    else $error("both-edge mode missed a transition");

  chk_rise_only:
    assert property (@(posedge clk) disable iff (!resetn)
      (ce && ch.edge_sel == icpt_pkg::EDGE_RISE && !(lvl_next && !lvl_reg)) |=> !evt_reg)
    else $error("rising-edge mode fired without a rise");

  chk_filter_hold:
    assert property (@(posedge clk) disable iff (!resetn)
      (ch.filt_en && !ch.filt_tick) |=> $stable(lvl_reg))
    else $error("filtered level moved between sampling ticks");

endmodule

`default_nettype wire

// >>> core/icpt_top.sv
/*
  input capture timer: free-running counter, two capture channels, shared
  interrupt, axi4-lite register slave.
  assumes one 100 mhz clock, synchronous active-low reset, async pins.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - a valid edge on pin a or b copies the counter into register a or b.
// - capture edge selectable as rising, falling or both.
// - edge field value 10 captures on both transitions of pin a.
// - every valid edge makes a fresh capture, so intervals can be measured.
// - a completed capture raises the timer interrupt only when its enable bit in ien is 1.
// - an enable lets counter overflow raise the interrupt.
// - a separate enable lets a capture edge raise the interrupt.
// - an optional digital filter conditions the pin before edge detection.
// - writing 1 to the run bit starts counting.
// - counting stops while run bit 7 of the mode register is 0.
// - gate bit 6 at 0 stops the clock, ignores writes other than to the gate bit, holds reset.
// - gate bit at 1 makes all timer registers readable; only the gate register, mode, ioctl, ien, clr and compare-mode gra/grb take writes.
// - mode bit 1 makes a general register capture; 0 makes it compare.
// - edge value 00 means rising, 01 falling; 11 is not to be used.
// - with the filter on, an edge is seen within five sampling ticks.
// - overflow raises the interrupt only when its enable bit 3 is 1.
module icpt_top #(
  parameter int CNT_W      = 16,
  parameter int FILT_AGREE = 3
) (
  // clock, reset, enable
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic                        ce,
  // axi4-lite write
  input  wire logic [icpt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // axi4-lite read
  input  wire logic [icpt_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // capture pins and interrupt
  input  wire logic                        capture_pin_a,
  input  wire logic                        capture_pin_b,
  output logic                             timer_irq
);

  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt
    $error("counter width must be 2 to 32");
  end

  localparam int AW = icpt_pkg::ADDR_W;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (dat & m);
  endfunction

  // bus group
  logic              awready_reg, awready_next, wready_reg, wready_next;
  logic              aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [AW-1:0]     awaddr_reg, awaddr_next;
  logic [31:0]       wdata_reg, wdata_next;
  logic [3:0]        wstrb_reg, wstrb_next;
  logic              bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic              rvalid_reg, rvalid_next;
  logic [1:0]        bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic              gate_reg, gate_next;
  // core group
  logic [7:0]        mode_reg, mode_next, ioctl_reg, ioctl_next, ien_reg, ien_next;
  logic [7:0]        stat_reg, stat_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next, gra_reg, gra_next, grb_reg, grb_next;
  logic [4:0]        pre_reg, pre_next;
  logic              irq_reg, irq_next;
  // decode and events
  logic [AW-1:0]     waddr, raddr;
  logic              wr_fire, rd_fire, wr_hit, core_rst_n, run;
  logic              mode_a, mode_b, cap_a, cap_b, cmp_a, cmp_b;
  logic [7:0]        set_mask, clr_mask;

  icpt_chan_if       ch_a ();
  icpt_chan_if       ch_b ();

  // ==========================================================
  // capture channels
  icpt_chan #(.FILT_AGREE(FILT_AGREE)) u_chan_a (
    .clk    (clk),
    .resetn (core_rst_n),
    .ce     (ce),
    .pin    (capture_pin_a),
    .ch     (ch_a.chan)
  );

  icpt_chan #(.FILT_AGREE(FILT_AGREE)) u_chan_b (
    .clk    (clk),
    .resetn (core_rst_n),
    .ce     (ce),
    .pin    (capture_pin_b),
    .ch     (ch_b.chan)
  );

  // ==========================================================
  // axi4-lite slave
  assign waddr   = {awaddr_reg[AW-1:2], 2'b00};
  assign raddr   = {s_axi_araddr[AW-1:2], 2'b00};
  assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign rd_fire = s_axi_arvalid && arready_reg;
  assign wr_hit  = (waddr <= icpt_pkg::OFF_GRB);

  always_comb begin
    aw_hold_next = aw_hold_reg;
    awaddr_next  = awaddr_reg;
    w_hold_next  = w_hold_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    gate_next    = gate_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_hold_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_hold_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_fire) begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_hit ? icpt_pkg::RESP_OKAY : icpt_pkg::RESP_SLVERR;
      if (waddr == icpt_pkg::OFF_PER_EN) begin
        gate_next = wstrb_reg[0] ? wdata_reg[icpt_pkg::PER_GATE_BIT] : gate_reg;
      end
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next  = icpt_pkg::RESP_OKAY;
      // gated-off core sits in reset, so reads show reset values
      unique case (raddr)
        icpt_pkg::OFF_PER_EN: rdata_next = 32'(gate_reg) << icpt_pkg::PER_GATE_BIT;
        icpt_pkg::OFF_MODE:   rdata_next = 32'(mode_reg);
        icpt_pkg::OFF_IOCTL:  rdata_next = 32'(ioctl_reg);
        icpt_pkg::OFF_IEN:    rdata_next = 32'(ien_reg);
        icpt_pkg::OFF_STAT:   rdata_next = 32'(stat_reg);
        icpt_pkg::OFF_CLR:    rdata_next = 32'h0000_0000;
        icpt_pkg::OFF_CNT:    rdata_next = 32'(cnt_reg);
        icpt_pkg::OFF_GRA:    rdata_next = 32'(gra_reg);
        icpt_pkg::OFF_GRB:    rdata_next = 32'(grb_reg);
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = icpt_pkg::RESP_SLVERR;
        end
      endcase
    end
    awready_next = !aw_hold_next;
    wready_next  = !w_hold_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= icpt_pkg::RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= icpt_pkg::RESP_OKAY;
      gate_reg    <= 1'b0;
    end else if (ce) begin
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      aw_hold_reg <= aw_hold_next;
      w_hold_reg  <= w_hold_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      gate_reg    <= gate_next;
    end
  end

  // ==========================================================
  // timer core
  assign core_rst_n = resetn & gate_reg;
  assign run        = mode_reg[icpt_pkg::MODE_RUN_BIT];
  assign mode_a     = ioctl_reg[icpt_pkg::IO_A_LSB + icpt_pkg::IO_MODE_OFS];
  assign mode_b     = ioctl_reg[icpt_pkg::IO_B_LSB + icpt_pkg::IO_MODE_OFS];
  assign cap_a      = ch_a.edge_evt && mode_a && run;
  assign cap_b      = ch_b.edge_evt && mode_b && run;
  assign cmp_a      = !mode_a && run && (cnt_reg == gra_reg);
  assign cmp_b      = !mode_b && run && (cnt_reg == grb_reg);

  assign ch_a.filt_en  = mode_reg[icpt_pkg::MODE_DFA_BIT];
  assign ch_b.filt_en  = mode_reg[icpt_pkg::MODE_DFB_BIT];
  assign ch_a.edge_sel = ioctl_reg[icpt_pkg::IO_A_LSB +: 2];
  assign ch_b.edge_sel = ioctl_reg[icpt_pkg::IO_B_LSB +: 2];
  // count source is the full clock, so the source choice samples every cycle
  always_comb begin
    unique case (mode_reg[icpt_pkg::MODE_FCK_LSB +: 2])
      icpt_pkg::FCK_DIV32: ch_a.filt_tick = (pre_reg == icpt_pkg::DIV32_LAST);
      icpt_pkg::FCK_DIV8:  ch_a.filt_tick = (pre_reg[2:0] == icpt_pkg::DIV8_LAST);
      default:             ch_a.filt_tick = 1'b1;
    endcase
  end
  assign ch_b.filt_tick = ch_a.filt_tick;

  always_comb begin
    mode_next  = mode_reg;
    ioctl_next = ioctl_reg;
    ien_next   = ien_reg;
    gra_next   = gra_reg;
    grb_next   = grb_reg;
    clr_mask   = 8'h00;
    pre_next   = pre_reg + 5'h01;
    cnt_next   = cnt_reg;
    if (run) begin
      cnt_next = cnt_reg + CNT_W'(1);
    end
    if (wr_fire) begin
      unique case (waddr)
        icpt_pkg::OFF_MODE:
          mode_next = 8'(merge(32'(mode_reg), wdata_reg, wstrb_reg)) & icpt_pkg::MODE_MASK;
        icpt_pkg::OFF_IOCTL:
          ioctl_next = 8'(merge(32'(ioctl_reg), wdata_reg, wstrb_reg)) & icpt_pkg::IOCTL_MASK;
        icpt_pkg::OFF_IEN:
          ien_next = 8'(merge(32'(ien_reg), wdata_reg, wstrb_reg)) & icpt_pkg::EV_MASK;
        icpt_pkg::OFF_CLR:
          clr_mask = wstrb_reg[0] ? (wdata_reg[7:0] & icpt_pkg::EV_MASK) : 8'h00;
        icpt_pkg::OFF_GRA:
          if (!mode_a) gra_next = CNT_W'(merge(32'(gra_reg), wdata_reg, wstrb_reg));
        icpt_pkg::OFF_GRB:
          if (!mode_b) grb_next = CNT_W'(merge(32'(grb_reg), wdata_reg, wstrb_reg));
        default: ;
      endcase
    end
    if (cap_a) gra_next = cnt_reg;
    if (cap_b) grb_next = cnt_reg;
    set_mask = 8'h00;
    set_mask[icpt_pkg::EV_CAPA_BIT] = cap_a | cmp_a;
    set_mask[icpt_pkg::EV_CAPB_BIT] = cap_b | cmp_b;
    set_mask[icpt_pkg::EV_OVF_BIT]  = run && (&cnt_reg);
    // a set in the clearing cycle survives
    stat_next = (stat_reg & ~clr_mask) | set_mask;
    irq_next  = |(stat_reg & ien_reg);
  end

  always_ff @(posedge clk) begin
    if (!core_rst_n) begin
      mode_reg  <= icpt_pkg::RST_BYTE;
      ioctl_reg <= icpt_pkg::RST_BYTE;
      ien_reg   <= icpt_pkg::RST_BYTE;
      stat_reg  <= icpt_pkg::RST_BYTE;
      cnt_reg   <= '0;
      gra_reg   <= '0;
      grb_reg   <= '0;
      pre_reg   <= 5'h00;
      irq_reg   <= 1'b0;
    end else if (ce) begin
      mode_reg  <= mode_next;
      ioctl_reg <= ioctl_next;
      ien_reg   <= ien_next;
      stat_reg  <= stat_next;
      cnt_reg   <= cnt_next;
      gra_reg   <= gra_next;
      grb_reg   <= grb_next;
      pre_reg   <= pre_next;
      irq_reg   <= irq_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign timer_irq     = irq_reg;

  // ==========================================================
  // checks
  chk_cap_copy_a:
    assert property (@(posedge clk) disable iff (!core_rst_n)
      (ce && cap_a) |=> (gra_reg == $past(cnt_reg)))
    else $error("capture a did not copy the counter");

  chk_cap_fresh_b:
    assert property (@(posedge clk) disable iff (!core_rst_n)
      (ce && cap_b) ##1 (ce && cap_b) |=> (grb_reg == $past(cnt_reg)))
    else $error("second capture b was not fresh");

  chk_count_run:
    assert property (@(posedge clk) disable iff (!core_rst_n)
      (ce && run) |=> (cnt_reg == CNT_W'($past(cnt_reg) + CNT_W'(1))))
    else $error("counter did not advance while running");

  chk_count_stop:
    assert property (@(posedge clk) disable iff (!core_rst_n)
      (ce && !run) |=> $stable(cnt_reg))
    else $error("counter moved while stopped");

  chk_ovf_wrap:
    assert property (@(posedge clk) disable iff (!core_rst_n)
      (ce && run && (&cnt_reg)) |=> (cnt_reg == '0) && stat_reg[icpt_pkg::EV_OVF_BIT])
    else $error("wrap did not set overflow");

  chk_gate_reset:
    assert property (@(posedge clk) disable iff (!resetn)
      !gate_reg |=> (cnt_reg == '0) && (mode_reg == icpt_pkg::RST_BYTE) && !timer_irq)
    else $error("gated-off timer left reset");

  chk_mode_write:
    assert property (@(posedge clk) disable iff (!core_rst_n)
      (ce && wr_fire && waddr == icpt_pkg::OFF_MODE && wstrb_reg[0]) |=>
      (mode_reg == ($past(wdata_reg[7:0]) & icpt_pkg::MODE_MASK)))
    else $error("mode write not stored");

  chk_irq_cap:
    assert property (@(posedge clk) disable iff (!core_rst_n)
      (ce && cap_a && ien_reg[icpt_pkg::EV_CAPA_BIT]) ##1 ce |=> timer_irq)
    else $error("capture did not raise the interrupt");

  chk_irq_mask:
    assert property (@(posedge clk) disable iff (!core_rst_n)
      (ce && (stat_reg & ien_reg) == 8'h00) |=> !timer_irq)
    else $error("masked event raised the interrupt");

endmodule

`default_nettype wire

// >>> verification/icpt_pulse_src.sv
/*
  pulse source standing on the capture pins of the timer.
  assumes one clock shared with the bench; pins change just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module icpt_pulse_src (
  // clock
  input  wire logic clk,
  // capture pins
  output logic      pin_a,
  output logic      pin_b
);
  // ==========================
  // pin drive
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end

  // level change at the next rising edge; the pin keeps that level until the next call
  task automatic drive(input int ch, input logic lvl);
    @(posedge clk);
    if (ch == 0) pin_a <= lvl;
    else pin_b <= lvl;
  endtask
endmodule

`default_nettype wire

// >>> verification/icpt_top_tb.sv
/*
  register-level test of the input capture timer over axi4-lite.
  assumes the pulse source model on the pins and a small counter width.
*/
`timescale 1ns/1ps
`default_nettype none

module icpt_top_tb;
  // ==========================
  // signals
  localparam int CW = 8;
  localparam int FA = 3;
  logic clk = 0, resetn = 0;
  logic [5:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, pa, pb;
  logic [1:0] bresp, rresp;
  int n_fail = 0, samples_checked = 0, cyc = 0, mark;
  logic [31:0] g1, g2, v;
  logic [1:0] r;
  logic ex, ce = 1;
  logic [1:0] wresp;

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  icpt_top #(.CNT_W(CW), .FILT_AGREE(FA)) u_dut (
    .clk(clk), .resetn(resetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .capture_pin_a(pa), .capture_pin_b(pb), .timer_irq(irq));

  icpt_pulse_src u_src (.clk(clk), .pin_a(pa), .pin_b(pb));

  // ==========================
  // tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask

  task automatic cut();
    n_fail++;
    conclude();
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask

  // master waits on ready and valid only; the timeout ends a hang
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    int k;
    logic ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (k = 0; k < 50 && !(ad && wd); k++) begin
      @(posedge clk);
      if (awvalid && awready) begin ad = 1; awvalid <= 0; end
      if (wvalid && wready) begin wd = 1; wvalid <= 0; end
    end
    if (!(ad && wd)) cut();
    for (k = 0; k < 50 && !(bvalid && bready); k++) @(posedge clk);
    if (!(bvalid && bready)) cut();
    wresp = bresp;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] re);
    int k;
    araddr <= a; arvalid <= 1; rready <= 1;
    for (k = 0; k < 50 && !(arvalid && arready); k++) @(posedge clk);
    if (!(arvalid && arready)) cut();
    arvalid <= 0;
    for (k = 0; k < 50 && !(rvalid && rready); k++) @(posedge clk);
    if (!(rvalid && rready)) cut();
    d = rdata;
    re = rresp;
  endtask

  // ==========================
  // tests
  initial begin
    w(5);
    resetn <= 1;
    w(2);
    for (int a = 0; a < 9; a++) begin
      rd(6'(4 * a), v, r); chk(v, 0);
    end
    rd(6'h24, v, r); chk(32'(r), 32'(icpt_pkg::RESP_SLVERR));
    wr(6'h24, 0); chk(32'(wresp), 32'(icpt_pkg::RESP_SLVERR));
    $display("test reset values done");
    wr(icpt_pkg::OFF_MODE, 32'h80); rd(icpt_pkg::OFF_MODE, v, r); chk(v, 0);
    wr(icpt_pkg::OFF_PER_EN, 32'h40); chk(32'(wresp), 32'(icpt_pkg::RESP_OKAY));
    rd(icpt_pkg::OFF_PER_EN, v, r); chk(v, 32'h40);
    // gra takes a write in compare mode; in capture mode it keeps its value
    wr(icpt_pkg::OFF_IOCTL, 32'h02); wr(icpt_pkg::OFF_GRA, 32'h55);
    rd(icpt_pkg::OFF_GRA, v, r); chk(v, 32'h55);
    wr(icpt_pkg::OFF_IOCTL, 32'h06); wr(icpt_pkg::OFF_GRA, 32'h33);
    rd(icpt_pkg::OFF_GRA, v, r); chk(v, 32'h55);
    $display("test gate and mode done");
    for (int e = 0; e < 4; e++) begin
      wr(icpt_pkg::OFF_MODE, 0); wr(icpt_pkg::OFF_IEN, 1);
      wr(icpt_pkg::OFF_IOCTL, 32'(4 | e)); wr(icpt_pkg::OFF_MODE, 32'h80);
      wr(icpt_pkg::OFF_CLR, 32'h0b);
      u_src.drive(0, 1); w(8); ex = (e == 0 || e == 2);
      rd(icpt_pkg::OFF_STAT, v, r); chk(v & 1, 32'(ex));
      chk(32'(irq), 32'(ex));
      wr(icpt_pkg::OFF_CLR, 1); w(3); chk(32'(irq), 0);
      u_src.drive(0, 0); w(8); ex = (e == 1 || e == 2);
      rd(icpt_pkg::OFF_STAT, v, r); chk(v & 1, 32'(ex));
      wr(icpt_pkg::OFF_CLR, 1);
    end
    $display("test edge select done");
    // both edges: two captures a known number of cycles apart
    wr(icpt_pkg::OFF_MODE, 0); wr(icpt_pkg::OFF_IOCTL, 32'h06);
    wr(icpt_pkg::OFF_MODE, 32'h80);
    mark = cyc;
    u_src.drive(0, 1); w(8); rd(icpt_pkg::OFF_GRA, g1, r);
    for (int k = 0; k < 200 && cyc < mark + 100; k++) @(posedge clk);
    if (cyc < mark + 100) cut();
    u_src.drive(0, 0); w(8); rd(icpt_pkg::OFF_GRA, g2, r);
    chk((g2 - g1) & 32'hff, 32'd100);
    // pin b toggles on two adjacent cycles; its last capture trails pin a by two
    wr(icpt_pkg::OFF_MODE, 0); wr(icpt_pkg::OFF_IOCTL, 32'h66);
    wr(icpt_pkg::OFF_MODE, 32'h80);
    u_src.drive(0, 1); u_src.drive(1, 1); u_src.drive(1, 0); w(8);
    rd(icpt_pkg::OFF_GRA, g1, r); rd(icpt_pkg::OFF_GRB, g2, r);
    chk((g2 - g1) & 32'hff, 32'd2);
    u_src.drive(0, 0); w(8);
    $display("test interval done");
    wr(icpt_pkg::OFF_MODE, 0); rd(icpt_pkg::OFF_CNT, g1, r); w(10);
    rd(icpt_pkg::OFF_CNT, g2, r); chk(g2, g1);
    wr(icpt_pkg::OFF_MODE, 32'h80); w(10); rd(icpt_pkg::OFF_CNT, g2, r);
    chk(32'(g2 != g1), 1);
    // clock enable low for 20 edges must not advance the counter
    rd(icpt_pkg::OFF_CNT, g1, r); ce <= 0; w(20); ce <= 1;
    rd(icpt_pkg::OFF_CNT, g2, r); chk((g2 - g1) & 32'hff, 32'd2);
    wr(icpt_pkg::OFF_IEN, 0); wr(icpt_pkg::OFF_CLR, 32'h0b); w((1 << CW) + 10);
    rd(icpt_pkg::OFF_STAT, v, r); chk(v & 8, 8);
    chk(32'(irq), 0);
    wr(icpt_pkg::OFF_IEN, 8); w(3); chk(32'(irq), 1);
    $display("test run and overflow done");
    wr(icpt_pkg::OFF_IEN, 1); wr(icpt_pkg::OFF_MODE, 0);
    wr(icpt_pkg::OFF_IOCTL, 32'h04);
    wr(icpt_pkg::OFF_MODE, 32'h24); wr(icpt_pkg::OFF_MODE, 32'ha4);
    wr(icpt_pkg::OFF_CLR, 32'h0b);
    u_src.drive(0, 1); u_src.drive(0, 0); w(10);
    rd(icpt_pkg::OFF_STAT, v, r); chk(v & 1, 0);
    u_src.drive(0, 1); w(FA + 5);
    rd(icpt_pkg::OFF_STAT, v, r); chk(v & 1, 1);
    // clk/8 sampling: a rise needs several slow ticks before it counts
    wr(icpt_pkg::OFF_MODE, 32'h14); u_src.drive(0, 0); w(40);
    wr(icpt_pkg::OFF_MODE, 32'h94); wr(icpt_pkg::OFF_CLR, 1);
    u_src.drive(0, 1); w(8);
    rd(icpt_pkg::OFF_STAT, v, r); chk(v & 1, 0);
    w(40); rd(icpt_pkg::OFF_STAT, v, r); chk(v & 1, 1);
    $display("test filter done");
    wr(icpt_pkg::OFF_PER_EN, 0); rd(icpt_pkg::OFF_CNT, v, r); chk(v, 0);
    conclude();
  end
endmodule

`default_nettype wire
